// ==== verilog/dct_regs.svh ====
// register offsets, field values and codes for the channel termination block
`ifndef DCT_REGS_SVH
`define DCT_REGS_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define DCT_A_STATUS 8'h00
`define DCT_A_FAULT 8'h04
`define DCT_A_CTRL 8'h08
`define DCT_A_CONFIG 8'h0C
`define DCT_A_MCOUNT 8'h10
`define DCT_A_BCOUNT 8'h14
`define DCT_A_MADDR 8'h18
`define DCT_A_BADDR 8'h1C
`define DCT_AV_AW 8
`define DCT_CNT_W 16
`define DCT_ADR_W 32
// control bits
`define DCT_CTL_START 7
`define DCT_CTL_CONT 6
`define DCT_CTL_SAB 4
`define DCT_CTL_IE 3
// field values
`define DCT_OP_BYTE 2'h0
`define DCT_OP_WORD 2'h1
`define DCT_OP_LONG 2'h2
`define DCT_OP_RSV 2'h3
`define DCT_CH_NONE 2'h0
`define DCT_CH_RSV 2'h1
`define DCT_CH_SEQ 2'h2
`define DCT_CH_LINK 2'h3
`define DCT_DESC_STEP 6
`endif

// ==== verilog/dct_pkg.sv ====
// types shared by the channel termination block
`default_nettype none
package dct_pkg;
  typedef struct packed {
    logic complete, bswitch, ended, fault, running, rsv2, line_evt, rsv0;
  } dct_flags_t;
  typedef struct packed {
    logic port8;
    logic [1:0] opsz;
    logic [1:0] chain;
    logic pcl_abort, dual, ext;
  } dct_cfg_t;
  typedef enum logic [2:0] {DCT_IDLE = 3'h1, DCT_RUN = 3'h2, DCT_DESC = 3'h4} dct_state_t;
  typedef enum logic [2:0] {
    DCT_F_NONE = 3'h0, DCT_F_CFG = 3'h1, DCT_F_TIM = 3'h2, DCT_F_ADR = 3'h3,
    DCT_F_BUS = 3'h4, DCT_F_CNT = 3'h5, DCT_F_EXT = 3'h6, DCT_F_SOFT = 3'h7
  } dct_fault_t;
  typedef struct packed {
    logic op_begin, op_done, bus_cycle, last_cycle, strobe;
    logic bus_master, odd_addr, bus_fault, desc_load;
    logic [15:0] desc_count;
    logic [31:0] desc_addr;
    logic [31:0] desc_link;
  } dct_xfer_t;
endpackage : dct_pkg
`default_nettype wire

// ==== verilog/dct_termination.sv ====
// channel termination and fault detection for one dma channel
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "dct_regs.svh"
module dct_termination #(
  parameter int CNT_W = `DCT_CNT_W,
  parameter int ADR_W = `DCT_ADR_W
) (
  input wire logic clock, // 125 MHz
  input wire logic rst, // async, active high
  input wire logic [`DCT_AV_AW-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // low for one cycle per answer
  input wire dct_pkg::dct_xfer_t xf, // transfer engine events
  input wire logic block_end_n_in, // block end pin level
  output logic block_end_out, // block end pin drive value
  output logic block_end_oe, // block end pin enable
  input wire logic dev_select_n_in, // device select pin
  input wire logic intr_ack_n_in, // interrupt acknowledge pin
  input wire logic periph_ctl_in, // peripheral control line
  output logic channel_active, // channel running
  output logic intr_req // interrupt request
);
  import dct_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  dct_state_t state, next_state;
  dct_flags_t flags, next_flags, wflags;
  dct_fault_t cause, next_cause, fcode;
  dct_cfg_t cfg, next_cfg;
  logic [CNT_W-1:0] mcount, next_mcount, bcount, next_bcount;
  logic [ADR_W-1:0] maddr, next_maddr, baddr, next_baddr;
  logic ie, next_ie, cnt, next_cnt;
  logic own_end, next_own_end, pend_end, next_pend_end, pend_dev, next_pend_dev;
  logic wait_q, next_wait, next_oe, next_intr, finish;
  logic [31:0] rdata, next_rdata;
  logic [2:0] be_s, cs_s, ia_s, pcl_s;
  logic be_f, next_be_f, cs_f, next_cs_f, ia_f, next_ia_f, pcl_f, next_pcl_f;
  logic pcl_prev;
  logic acc, wr, wr_ctl, start_req, stale, intrude, busy;

  function automatic logic [ADR_W-1:0] step(input logic [1:0] sz);
    case (sz)
      `DCT_OP_WORD: step = ADR_W'(2);
      `DCT_OP_LONG: step = ADR_W'(4);
      default: step = ADR_W'(1);
    endcase
  endfunction : step

  // reserved chain/size codes, or wide operand on a single-address 8-bit port
  function automatic logic cfg_bad(input dct_cfg_t c);
    cfg_bad = (c.opsz == `DCT_OP_RSV) || (c.chain == `DCT_CH_RSV) ||
              (c.port8 && !c.dual && c.opsz != `DCT_OP_BYTE);
  endfunction : cfg_bad

  assign avs_readdata = rdata;
  assign avs_waitrequest = wait_q;
  assign channel_active = flags.running;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_flags = flags;
    next_cause = cause;
    next_cfg = cfg;
    next_mcount = mcount;
    next_bcount = bcount;
    next_maddr = maddr;
    next_baddr = baddr;
    next_ie = ie;
    next_cnt = cnt;
    next_own_end = own_end;
    next_pend_end = pend_end;
    next_pend_dev = pend_dev;
    next_wait = 1'b1;
    next_rdata = rdata;
    next_be_f = be_f;
    next_cs_f = cs_f;
    next_ia_f = ia_f;
    next_pcl_f = pcl_f;
    fcode = DCT_F_NONE;
    finish = 1'b0;
    wflags = dct_flags_t'(avs_writedata[$bits(dct_flags_t)-1:0]);
    busy = flags.running;
    // a change counts once the two later stages agree
    if (be_s[1] == be_s[2]) next_be_f = be_s[2];
    if (cs_s[1] == cs_s[2]) next_cs_f = cs_s[2];
    if (ia_s[1] == ia_s[2]) next_ia_f = ia_s[2];
    if (pcl_s[1] == pcl_s[2]) next_pcl_f = pcl_s[2];
    intrude = xf.bus_master && (cs_f || ia_f);
    acc = (avs_read || avs_write) && !wait_q;
    // an access colliding with our own bus ownership changes nothing
    wr = acc && avs_write && !intrude;
    wr_ctl = wr && (avs_address == `DCT_A_CTRL);
    start_req = wr_ctl && avs_writedata[`DCT_CTL_START];
    stale = flags.running || flags.complete || flags.bswitch || flags.ended || flags.fault;

    if ((avs_read || avs_write) && wait_q) begin
      next_wait = 1'b0;
      case (avs_address)
        `DCT_A_STATUS: next_rdata = 32'(flags);
        `DCT_A_FAULT: next_rdata = 32'(cause);
        `DCT_A_CTRL: next_rdata = 32'({cnt, 2'h0, ie, 3'h0} << 0);
        `DCT_A_CONFIG: next_rdata = 32'(cfg);
        `DCT_A_MCOUNT: next_rdata = 32'(mcount);
        `DCT_A_BCOUNT: next_rdata = 32'(bcount);
        `DCT_A_MADDR: next_rdata = 32'(maddr);
        `DCT_A_BADDR: next_rdata = 32'(baddr);
        default: next_rdata = 32'h0000_0000;
      endcase
    end

    if (wr) begin
      case (avs_address)
        `DCT_A_STATUS: begin
          next_flags.complete = flags.complete && !wflags.complete;
          next_flags.bswitch = flags.bswitch && !wflags.bswitch;
          next_flags.ended = flags.ended && !wflags.ended;
          next_flags.fault = flags.fault && !wflags.fault;
          next_flags.line_evt = flags.line_evt && !wflags.line_evt;
          if (wflags.fault) next_cause = DCT_F_NONE;
        end
        `DCT_A_CONFIG: if (busy) fcode = DCT_F_TIM; else next_cfg = dct_cfg_t'(avs_writedata[7:0]);
        `DCT_A_MCOUNT: if (busy) fcode = DCT_F_TIM; else next_mcount = avs_writedata[CNT_W-1:0];
        `DCT_A_BCOUNT: if (busy) fcode = DCT_F_TIM; else next_bcount = avs_writedata[CNT_W-1:0];
        `DCT_A_MADDR: if (busy) fcode = DCT_F_TIM; else next_maddr = avs_writedata[ADR_W-1:0];
        `DCT_A_BADDR: if (busy) fcode = DCT_F_TIM; else next_baddr = avs_writedata[ADR_W-1:0];
        default: ;
      endcase
    end

    if (wr_ctl) begin
      next_ie = avs_writedata[`DCT_CTL_IE];
      if (start_req) begin
        if (stale) fcode = DCT_F_TIM;
        else if (cfg_bad(cfg)) fcode = DCT_F_CFG;
        else if (cfg.chain == `DCT_CH_NONE && mcount == '0) fcode = DCT_F_CNT;
        else if (cfg.chain == `DCT_CH_SEQ && bcount == '0) fcode = DCT_F_CNT;
        else begin
          next_state = (cfg.chain == `DCT_CH_NONE) ? DCT_RUN : DCT_DESC;
          next_flags.running = 1'b1;
          next_cnt = avs_writedata[`DCT_CTL_CONT];
          next_own_end = 1'b0;
          next_pend_end = 1'b0;
          next_pend_dev = 1'b0;
        end
      end else if (avs_writedata[`DCT_CTL_CONT]) begin
        if (!flags.running || flags.bswitch) fcode = DCT_F_TIM;
        else next_cnt = 1'b1;
      end
      if (avs_writedata[`DCT_CTL_SAB] && busy && fcode == DCT_F_NONE) fcode = DCT_F_SOFT;
    end

    // set after the clear so a new edge is never lost
    if (pcl_f && !pcl_prev) next_flags.line_evt = 1'b1;

    case (state)
      DCT_IDLE: ;
      DCT_RUN: begin
        if (xf.op_begin && mcount == CNT_W'(1) && cfg.ext) next_own_end = 1'b1;
        if (cfg.ext && be_f && (cfg.dual ? xf.bus_cycle : xf.strobe)) begin
          // own drive echoes on the pin: the count path ends it, a continue survives it
          if (!own_end) begin
            next_pend_end = 1'b1;
            next_pend_dev = 1'b1;
          end
        end
        // odd address cycles are refused before any count or address moves
        if (xf.op_done && !xf.odd_addr) begin
          next_mcount = mcount - CNT_W'(1);
          next_maddr = maddr + step(cfg.opsz);
          // early end waits for the operand's last cycle, even on a narrow port
          if (next_pend_end) begin
            finish = 1'b1;
            next_flags.ended = next_pend_dev;
          end else if (mcount == CNT_W'(1)) begin
            if (cnt) begin
              if (bcount == '0) fcode = DCT_F_CNT;
              else begin
                next_mcount = bcount;
                next_maddr = baddr;
                next_cnt = 1'b0;
                next_flags.bswitch = 1'b1;
                next_own_end = 1'b0;
              end
            end else if ((cfg.chain == `DCT_CH_SEQ && bcount != '0) ||
                         (cfg.chain == `DCT_CH_LINK && baddr != '0)) begin
              next_state = DCT_DESC;
              next_own_end = 1'b0;
            end else finish = 1'b1;
          end
        end
      end
      DCT_DESC: begin
        if (xf.desc_load) begin
          if (xf.desc_count[CNT_W-1:0] == '0) fcode = DCT_F_CNT;
          else begin
            next_mcount = xf.desc_count[CNT_W-1:0];
            next_maddr = xf.desc_addr[ADR_W-1:0];
            if (cfg.chain == `DCT_CH_SEQ) begin
              next_bcount = bcount - CNT_W'(1);
              next_baddr = baddr + ADR_W'(`DCT_DESC_STEP);
            end else next_baddr = xf.desc_link[ADR_W-1:0];
            next_state = DCT_RUN;
          end
        end
      end
      default: next_state = DCT_IDLE;
    endcase

    if (busy && fcode == DCT_F_NONE) begin
      if (xf.bus_fault) fcode = DCT_F_BUS;
      else if (xf.odd_addr) fcode = DCT_F_ADR;
      else if (intrude) fcode = DCT_F_ADR;
      else if (cfg.pcl_abort && flags.line_evt) fcode = DCT_F_EXT;
    end
    if (fcode != DCT_F_NONE) begin
      next_flags.fault = 1'b1;
      next_cause = fcode;
      finish = 1'b1;
    end
    // address faults leave counts and addresses as they were
    if (fcode == DCT_F_ADR) begin
      next_mcount = mcount;
      next_maddr = maddr;
      next_bcount = bcount;
      next_baddr = baddr;
    end
    if (finish) begin
      next_state = DCT_IDLE;
      next_flags.running = 1'b0;
      next_flags.complete = 1'b1;
      next_cnt = 1'b0;
      next_own_end = 1'b0;
      next_pend_end = 1'b0;
      next_pend_dev = 1'b0;
    end
    next_oe = next_own_end && xf.bus_cycle && xf.last_cycle;
    next_intr = next_ie && (next_flags.complete || next_flags.bswitch || next_flags.fault);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= DCT_IDLE;
      flags <= '0;
      cause <= DCT_F_NONE;
      cfg <= '0;
      mcount <= '0;
      bcount <= '0;
      maddr <= '0;
      baddr <= '0;
      ie <= 1'b0;
      cnt <= 1'b0;
      own_end <= 1'b0;
      pend_end <= 1'b0;
      pend_dev <= 1'b0;
      wait_q <= 1'b1;
      rdata <= 32'h0000_0000;
      block_end_oe <= 1'b0;
      block_end_out <= 1'b1;
      intr_req <= 1'b0;
      be_s <= 3'h0;
      cs_s <= 3'h0;
      ia_s <= 3'h0;
      pcl_s <= 3'h0;
      be_f <= 1'b0;
      cs_f <= 1'b0;
      ia_f <= 1'b0;
      pcl_f <= 1'b0;
      pcl_prev <= 1'b0;
    end else begin
      state <= next_state;
      flags <= next_flags;
      cause <= next_cause;
      cfg <= next_cfg;
      mcount <= next_mcount;
      bcount <= next_bcount;
      maddr <= next_maddr;
      baddr <= next_baddr;
      ie <= next_ie;
      cnt <= next_cnt;
      own_end <= next_own_end;
      pend_end <= next_pend_end;
      pend_dev <= next_pend_dev;
      wait_q <= next_wait;
      rdata <= next_rdata;
      block_end_oe <= next_oe;
      block_end_out <= !next_oe;
      intr_req <= next_intr;
      be_s <= {be_s[1:0], !block_end_n_in};
      cs_s <= {cs_s[1:0], !dev_select_n_in};
      ia_s <= {ia_s[1:0], !intr_ack_n_in};
      pcl_s <= {pcl_s[1:0], periph_ctl_in};
      be_f <= next_be_f;
      cs_f <= next_cs_f;
      ia_f <= next_ia_f;
      pcl_f <= next_pcl_f;
      pcl_prev <= pcl_f;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking dct_cb @(posedge clock); endclocking
  default disable iff (rst);

  a_start_stale_refused:
    assert property (start_req && stale |=> flags.fault && cause == DCT_F_TIM && state == DCT_IDLE)
      else $error("start with stale status not refused");
  a_count_zero_start:
    assert property (start_req && !stale && !cfg_bad(cfg) && cfg.chain == `DCT_CH_NONE && mcount == '0
                     |=> cause == DCT_F_CNT && !flags.running)
      else $error("zero count start not refused");
  a_block_end_drive:
    assert property ($rose(block_end_oe) |-> $past(xf.last_cycle) && $past(cfg.ext))
      else $error("block end driven outside last cycle");
  a_normal_end:
    assert property (state == DCT_RUN && xf.op_done && !xf.odd_addr && mcount == CNT_W'(1) && !cnt &&
                     !next_pend_end && cfg.chain == `DCT_CH_NONE && fcode == DCT_F_NONE
                     |=> !flags.running && flags.complete && mcount == '0)
      else $error("count exhaustion did not end channel");
  a_device_end_flag:
    assert property (state == DCT_RUN && xf.op_done && !xf.odd_addr && pend_dev && fcode == DCT_F_NONE
                     |=> flags.ended && flags.complete && !flags.running)
      else $error("peripheral end not flagged");
  a_own_end_quiet:
    assert property (state == DCT_RUN && own_end && xf.op_done && fcode == DCT_F_NONE |=> !flags.ended)
      else $error("own block end flagged as peripheral end");
  a_fault_marks:
    assert property ($rose(flags.fault) |-> flags.complete && cause != DCT_F_NONE && !flags.running)
      else $error("fault without complete or cause");
  a_bus_fault_stop:
    assert property (state != DCT_IDLE && xf.bus_fault |=> cause == DCT_F_BUS ##1 state == DCT_IDLE)
      else $error("bus fault not recorded");
  a_block_switch:
    assert property (state == DCT_RUN && xf.op_done && !xf.odd_addr && mcount == CNT_W'(1) && cnt &&
                     bcount != '0 && !next_pend_end && fcode == DCT_F_NONE
                     |=> flags.bswitch && flags.running && mcount == $past(bcount))
      else $error("continue did not reload base count");
  a_end_filter:
    assert property ($rose(be_f) |-> $past(be_s[1]) && $past(be_s[2]))
      else $error("block end taken on single sample");

  c_normal_end: cover property (state == DCT_RUN ##1 flags.complete && !flags.fault && !flags.ended);
  c_device_end: cover property ($rose(flags.ended));
  c_switch: cover property ($rose(flags.bswitch));
  c_fault: cover property ($rose(flags.fault) && cause == DCT_F_CNT);
endmodule : dct_termination
`default_nettype wire

// ==== tb/dct_partner.sv ====
// peripheral and transfer engine model facing the channel termination block
`timescale 1ns/10ps
`default_nettype none
module dct_partner
  import dct_pkg::*;
(
  input wire logic clock, // bench clock
  input wire logic rst, // async, active high
  input wire logic go, // start one operand transfer
  input wire logic [1:0] mode, // 0 plain, 1 peripheral end, 2 bus fault, 3 odd address
  input wire logic load, // descriptor read finished
  input wire logic [15:0] load_count, // count held in that descriptor
  output var dct_pkg::dct_xfer_t xf, // transfer events
  output logic periph_end_n, // peripheral pull on block end, pulled up when released
  output logic busy // transfer in progress
);
  logic [3:0] ph;
  logic [1:0] md;
  // ---------------------------------------------------------------
  // phase counter, one operand per go
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph <= 4'h0;
      md <= 2'h0;
    end else if (go && ph == 4'h0) begin
      ph <= 4'h1;
      md <= mode;
    end else if (ph != 4'h0) begin
      ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
    end
  end
  always_comb begin
    xf = '0;
    busy = ph != 4'h0;
    xf.bus_master = busy && md != 2'h3;
    xf.op_begin = ph == 4'h1 && md != 2'h3;
    xf.odd_addr = ph == 4'h1 && md == 2'h3;
    xf.bus_cycle = ph >= 4'h2 && ph <= 4'h7 && md != 2'h3;
    xf.last_cycle = xf.bus_cycle;
    xf.strobe = xf.bus_cycle;
    xf.op_done = ph == 4'h8 && md < 2'h2;
    xf.bus_fault = ph == 4'h8 && md == 2'h2;
    xf.desc_load = load;
    xf.desc_count = load_count;
    xf.desc_addr = 32'h0000_0100;
    // held five clocks so both sync samples agree
    periph_end_n = !(md == 2'h1 && ph >= 4'h2 && ph <= 4'h6);
  end
endmodule : dct_partner
`default_nettype wire

// ==== tb/test_dct_termination.sv ====
// self-checking bench for the channel termination block
`timescale 1ns/10ps
`default_nettype none
`include "dct_regs.svh"
module test_dct_termination;
  import dct_pkg::*;
  typedef struct packed {
    logic [7:0] cfg;
    logic [15:0] mc;
    logic [15:0] bc;
    logic [1:0] md;
    logic run;
    logic [7:0] st;
    logic [2:0] fc;
    logic oe;
  } dct_row_t;
  logic clock, rst, avs_read, avs_write, dev_select_n_in, intr_ack_n_in, periph_ctl_in, go, load;
  logic [15:0] load_count;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic avs_waitrequest, block_end_out, block_end_oe, channel_active, intr_req, p_busy, periph_end_n;
  logic [1:0] mode;
  wire logic block_end_n_in;
  dct_xfer_t xf;
  dct_row_t r;
  int err_total, compares, cyc, oe_cnt, o0;
  // cfg, count, base count, op mode, run op, status, cause, own end seen
  dct_row_t rows [11] = '{
    '{8'h01, 16'h0001, 16'h0001, 2'h0, 1'b1, 8'h80, 3'h0, 1'b1},
    '{8'h01, 16'h0001, 16'h0001, 2'h1, 1'b1, 8'h80, 3'h0, 1'b1},
    '{8'h01, 16'h0005, 16'h0001, 2'h1, 1'b1, 8'hA0, 3'h0, 1'b0},
    '{8'hA3, 16'h0005, 16'h0001, 2'h1, 1'b1, 8'hA0, 3'h0, 1'b0},
    '{8'h01, 16'h0000, 16'h0001, 2'h0, 1'b0, 8'h90, 3'h5, 1'b0},
    '{8'h61, 16'h0005, 16'h0001, 2'h0, 1'b0, 8'h90, 3'h1, 1'b0},
    '{8'h09, 16'h0005, 16'h0001, 2'h0, 1'b0, 8'h90, 3'h1, 1'b0},
    '{8'hA1, 16'h0005, 16'h0001, 2'h0, 1'b0, 8'h90, 3'h1, 1'b0},
    '{8'h11, 16'h0005, 16'h0000, 2'h0, 1'b0, 8'h90, 3'h5, 1'b0},
    '{8'h01, 16'h0005, 16'h0001, 2'h2, 1'b1, 8'h90, 3'h4, 1'b0},
    '{8'h01, 16'h0005, 16'h0001, 2'h3, 1'b1, 8'h90, 3'h3, 1'b0}
  };
  // open-drain block end line with pull-up
  assign block_end_n_in = periph_end_n & ~(block_end_oe & ~block_end_out);
  dct_termination dct_termination_inst (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .xf(xf), .block_end_n_in(block_end_n_in),
    .block_end_out(block_end_out), .block_end_oe(block_end_oe), .dev_select_n_in(dev_select_n_in),
    .intr_ack_n_in(intr_ack_n_in), .periph_ctl_in(periph_ctl_in), .channel_active(channel_active),
    .intr_req(intr_req));
  dct_partner dct_partner_inst (.clock(clock), .rst(rst), .go(go), .mode(mode), .load(load),
    .load_count(load_count), .xf(xf),
    .periph_end_n(periph_end_n), .busy(p_busy));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task final_report;
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task chk(input logic ok, input string m);
    compares++;
    if (!ok) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  // request held until waitrequest sampled low; one idle edge afterwards
  task bus_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : bus_acc
  task op(input logic [1:0] m, input logic sel);
    int n;
    n = 0;
    mode <= m;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (3) @(posedge clock);
    dev_select_n_in <= !sel;
    repeat (2) @(posedge clock);
    dev_select_n_in <= 1'b1;
    while (p_busy === 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
    end
    repeat (6) @(posedge clock);
  endtask : op
  task start(input logic [7:0] cfg, input logic [15:0] mc, input logic [15:0] bc, input logic [7:0] ctl);
    bus_acc(1'b1, `DCT_A_STATUS, 32'h000000FF);
    bus_acc(1'b1, `DCT_A_CONFIG, {24'h0, cfg});
    bus_acc(1'b1, `DCT_A_MCOUNT, {16'h0, mc});
    bus_acc(1'b1, `DCT_A_BCOUNT, {16'h0, bc});
    bus_acc(1'b1, `DCT_A_CTRL, {24'h0, ctl});
  endtask : start
  // one-cycle descriptor read result
  task desc(input logic [15:0] c);
    load_count <= c;
    load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
  endtask : desc
  task fault_is(input logic [2:0] fc);
    repeat (4) @(posedge clock);
    bus_acc(1'b0, `DCT_A_FAULT, 32'h0);
    chk(rd[2:0] === fc, "fault cause");
  endtask : fault_is
  always @(posedge clock) begin
    cyc++;
    if (block_end_oe === 1'b1 && block_end_out === 1'b0)
      oe_cnt++;
    if (cyc == 8000) begin
      err_total++;
      $display("unexpected at %0t: run hung", $time);
      final_report;
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, go, periph_ctl_in, load} = 5'h00;
    load_count = 16'h0000;
    {dev_select_n_in, intr_ack_n_in} = 2'h3;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    mode = 2'h0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk(avs_waitrequest === 1'b1 && block_end_oe === 1'b0 && channel_active === 1'b0, "reset outputs");
    chk(intr_req === 1'b0, "reset interrupt");
    bus_acc(1'b0, 8'hFC, 32'h0);
    chk(rd === 32'h0, "unmapped read");
    $display("test reset done");
    foreach (rows[i]) begin
      r = rows[i];
      start(r.cfg, r.mc, r.bc, 8'h88);
      o0 = oe_cnt;
      if (r.run)
        op(r.md, 1'b0);
      else
        repeat (4) @(posedge clock);
      bus_acc(1'b0, `DCT_A_STATUS, 32'h0);
      chk(rd[7:0] === r.st, "status flags");
      fault_is(r.fc);
      chk(intr_req === 1'b1, "interrupt");
      chk((oe_cnt > o0) === r.oe, "own block end");
      if (r.run && r.md != 2'h2) begin
        bus_acc(1'b0, `DCT_A_MCOUNT, 32'h0);
        chk(rd[15:0] === ((r.md == 2'h3) ? r.mc : r.mc - 16'h1), "count");
      end
      $display("test row %0d done", i);
    end
    bus_acc(1'b1, `DCT_A_CTRL, 32'h00000080);
    fault_is(3'h2);
    start(8'h01, 16'h0005, 16'h0001, 8'h80);
    chk(channel_active === 1'b1, "running");
    bus_acc(1'b1, `DCT_A_MCOUNT, 32'h00000003);
    fault_is(3'h2);
    chk(channel_active === 1'b0, "abort on busy write");
    start(8'h01, 16'h0005, 16'h0001, 8'h40);
    fault_is(3'h2);
    start(8'h01, 16'h0005, 16'h0001, 8'h80);
    op(2'h0, 1'b1);
    fault_is(3'h3);
    bus_acc(1'b0, `DCT_A_MCOUNT, 32'h0);
    chk(rd[15:0] === 16'h0005, "count kept");
    start(8'h01, 16'h0005, 16'h0001, 8'h80);
    bus_acc(1'b1, `DCT_A_CTRL, 32'h00000010);
    fault_is(3'h7);
    start(8'h05, 16'h0005, 16'h0001, 8'h80);
    periph_ctl_in <= 1'b1;
    repeat (3) @(posedge clock);
    periph_ctl_in <= 1'b0;
    fault_is(3'h6);
    start(8'h01, 16'h0001, 16'h0000, 8'hC0);
    op(2'h0, 1'b0);
    fault_is(3'h5);
    start(8'h11, 16'h0005, 16'h0001, 8'h80);
    desc(16'h0000);
    fault_is(3'h5);
    bus_acc(1'b0, `DCT_A_BCOUNT, 32'h0);
    chk(rd[15:0] === 16'h0001, "base count kept");
    start(8'h11, 16'h0005, 16'h0002, 8'h80);
    desc(16'h0003);
    bus_acc(1'b0, `DCT_A_BCOUNT, 32'h0);
    chk(rd[15:0] === 16'h0001, "base count stepped");
    bus_acc(1'b0, `DCT_A_MCOUNT, 32'h0);
    chk(rd[15:0] === 16'h0003, "descriptor count loaded");
    bus_acc(1'b1, `DCT_A_CTRL, 32'h00000010);
    fault_is(3'h7);
    start(8'h01, 16'h0001, 16'h0003, 8'hC0);
    op(2'h0, 1'b0);
    bus_acc(1'b0, `DCT_A_STATUS, 32'h0);
    chk(rd[7:0] === 8'h48, "block switched");
    bus_acc(1'b0, `DCT_A_MCOUNT, 32'h0);
    chk(rd[15:0] === 16'h0003, "count reloaded");
    $display("test fault cases done");
    final_report;
  end
endmodule : test_dct_termination
`default_nettype wire
